/* File: src/smbus_cfg_pkg.sv */
package smbus_cfg_pkg;

  // Fixed slave address that the device answers to.
  localparam logic [6:0] DEV_ADDR = 7'h69;

  // Offsets of the four configuration bytes, carried in the command code.
  localparam logic [6:0] OFF_SPREAD_FREQ = 7'h00;
  localparam logic [6:0] OFF_CPU_AGP_USB = 7'h01;
  localparam logic [6:0] OFF_PCI_LOW = 7'h02;
  localparam logic [6:0] OFF_PCI_REF = 7'h03;

  // Power-on values; reserved bits sit at zero.
  localparam logic [7:0] RST_SPREAD_FREQ = 8'h00;
  localparam logic [7:0] RST_CPU_AGP_USB = 8'hf7;
  localparam logic [7:0] RST_PCI_LOW = 8'hff;
  localparam logic [7:0] RST_PCI_REF = 8'hdb;

  // Writable bits of each byte; reserved bits are held at zero.
  localparam logic [7:0] MASK_SPREAD_FREQ = 8'hff;
  localparam logic [7:0] MASK_CPU_AGP_USB = 8'hf7;
  localparam logic [7:0] MASK_PCI_LOW = 8'hff;
  localparam logic [7:0] MASK_PCI_REF = 8'hdb;

  // Field positions inside the configuration bytes and the command code.
  localparam int SPREAD_ENABLE_BIT = 7;
  localparam int SPREAD_RANGE_LSB = 4;
  localparam int CMD_BYTE_OP_BIT = 7;
  localparam int CPU_PAIR0_ENABLE_BIT = 7;
  localparam int USB_CLOCK_ENABLE_BIT = 5;
  localparam int PCI_FREE_ENABLE_BIT = 7;
  localparam int REFCLK0_ENABLE_BIT = 0;

  // Bit times of a transaction, counted from the start condition as 1.
  localparam logic [5:0] POS_START = 6'h01;
  localparam logic [5:0] POS_DIR = 6'h09;
  localparam logic [5:0] POS_ADDR_ACK = 6'h0a;
  localparam logic [5:0] POS_CMD_ACK = 6'h13;
  localparam logic [5:0] POS_RSTART = 6'h14;
  localparam logic [5:0] POS_WR_ACK = 6'h1c;
  localparam logic [5:0] POS_WR_STOP = 6'h1d;
  localparam logic [5:0] POS_RD_DIR = 6'h1c;
  localparam logic [5:0] POS_RD_ACK = 6'h1d;
  localparam logic [5:0] POS_RD_FIRST = 6'h1e;
  localparam logic [5:0] POS_RD_LAST = 6'h25;
  localparam logic [5:0] POS_RD_NACK = 6'h26;
  localparam logic [5:0] POS_RD_STOP = 6'h27;

  // Serial clock made by the host, and its quarter period in mclk cycles.
  localparam int MCLK_PERIOD_NS = 100;
  localparam int SCL_PERIOD_NS = 1600;
  localparam logic [3:0] SCL_QTR_CYCLES = 4'((SCL_PERIOD_NS / 4) / MCLK_PERIOD_NS);

  // Host register map on APB.
  localparam logic [7:0] APB_CTRL = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam int CTRL_READ_BIT = 16;

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_addr = 3'b001,
    st_ack = 3'b010,
    st_cmd = 3'b011,
    st_wdata = 3'b100,
    st_rdata = 3'b101,
    st_rack = 3'b110,
    st_ignore = 3'b111
  } dev_state_t;

  typedef enum logic [2:0] {
    k_bit = 3'b000,
    k_ack = 3'b001,
    k_start = 3'b010,
    k_stop = 3'b011,
    k_rx = 3'b100
  } slot_kind_t;

endpackage

/* File: src/smbus_if.sv */
`timescale 1ns/100ps
// Open-drain serial link; a driver that is enabled pulls its line to its out value, low in practice.
interface smbus_if;
  logic scl_out;
  logic scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Pull-ups keep both lines high unless somebody pulls them low.
  assign scl = !(scl_oe && !scl_out);
  assign sda = !((host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out));

  modport host (output scl_out, output scl_oe, output host_sda_out, output host_sda_oe, input sda);
  modport device (output dev_sda_out, output dev_sda_oe, input scl, input sda);
endinterface

/* File: src/smbus_cfg_device.sv */
`timescale 1ns/100ps
// What this block does
// - Byte write: address, command, data, acknowledged each
// - Byte read: command, repeated start, read address
// - Read returns eight bits, host nacks, stops
// - Command with top bit set is byte access
// - Low seven command bits select the byte
// - Serial bits arrive most significant first
// - Host writes zero to reserved bits; this host sends them as software gives them and the device masks them off
// - Host zeroes bits marked initialize to zero; this host sends every bit as software gives it
// - Byte 0: spread enable and range select
// - Byte 0 low nibble: software frequency bits
// - Byte 1: CPU, USB, graphics clock enables
// - Byte 2: PCI clocks seven to zero enables
// - Byte 3: free PCI, PCI 9/8, reference enables
// - Software frequency used only when override set
module smbus_cfg_device (
  input wire logic mclk,
  input wire logic rstn,
  smbus_if.device bus,
  input wire logic [4:0] fs_strap,
  input wire logic strap_override,
  input wire logic sw_freq_bit4,
  output logic [7:0] spread_and_freq_select,
  output logic [7:0] cpu_agp_usb_clock_enables,
  output logic [7:0] pci_clock_enables_low,
  output logic [7:0] pci_ref_clock_enables_high,
  output logic [4:0] freq_select
);

  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_prev;
  logic sda_prev;
  logic [4:0] strap_sync0;
  logic [4:0] strap_sync1;
  logic [4:0] strap_latched;
  logic [1:0] strap_wait;
  smbus_cfg_pkg::dev_state_t state;
  smbus_cfg_pkg::dev_state_t after_ack;
  logic [3:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic [6:0] offset;
  logic cmd_valid;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] rd_byte;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  // Both lines come from another domain, so each passes two flops before any logic looks at it.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], bus.scl};
      sda_sync <= {sda_sync[0], bus.sda};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  // Edges and bus conditions are judged only on the second synchroniser stage and its delayed copy.
  assign scl_rise = scl_sync[1] && !scl_prev;
  assign scl_fall = !scl_sync[1] && scl_prev;
  assign start_seen = scl_sync[1] && scl_prev && sda_prev && !sda_sync[1];
  assign stop_seen = scl_sync[1] && scl_prev && !sda_prev && sda_sync[1];

  // Read value of the selected byte; offsets past byte 3 read as zero.
  always_comb
  begin
    unique case (offset)
      smbus_cfg_pkg::OFF_SPREAD_FREQ: rd_byte = spread_and_freq_select & smbus_cfg_pkg::MASK_SPREAD_FREQ;
      smbus_cfg_pkg::OFF_CPU_AGP_USB: rd_byte = cpu_agp_usb_clock_enables & smbus_cfg_pkg::MASK_CPU_AGP_USB;
      smbus_cfg_pkg::OFF_PCI_LOW: rd_byte = pci_clock_enables_low & smbus_cfg_pkg::MASK_PCI_LOW;
      smbus_cfg_pkg::OFF_PCI_REF: rd_byte = pci_ref_clock_enables_high & smbus_cfg_pkg::MASK_PCI_REF;
      default: rd_byte = 8'h00;
    endcase
  end

  // Protocol engine. Input bits are taken on the rising clock edge, and the
  // device changes its data line only after a falling edge, so it never makes a
  // false start or stop while the clock is high.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= smbus_cfg_pkg::st_idle;
      after_ack <= smbus_cfg_pkg::st_idle;
      bit_cnt <= 4'h0;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      offset <= 7'h00;
      cmd_valid <= 1'b0;
      wr_en <= 1'b0;
      wr_data <= 8'h00;
      bus.dev_sda_oe <= 1'b0;
    end
    else
    begin
      wr_en <= 1'b0;
      if (start_seen)
      begin
        // A repeated start keeps the offset so that a read can follow its command.
        state <= smbus_cfg_pkg::st_addr;
        bit_cnt <= 4'h0;
        bus.dev_sda_oe <= 1'b0;
      end
      else if (stop_seen)
      begin
        state <= smbus_cfg_pkg::st_idle;
        cmd_valid <= 1'b0;
        bus.dev_sda_oe <= 1'b0;
      end
      else if (scl_rise)
      begin
        unique case (state)
          smbus_cfg_pkg::st_addr, smbus_cfg_pkg::st_cmd, smbus_cfg_pkg::st_wdata:
          begin
            rx_shift <= {rx_shift[6:0], sda_sync[1]};
            bit_cnt <= 4'(bit_cnt + 4'h1);
          end
          smbus_cfg_pkg::st_rdata: bit_cnt <= 4'(bit_cnt + 4'h1);
          // Only single bytes are served, so the host's answer always ends the read.
          smbus_cfg_pkg::st_rack: state <= smbus_cfg_pkg::st_ignore;
          smbus_cfg_pkg::st_idle, smbus_cfg_pkg::st_ack, smbus_cfg_pkg::st_ignore: ;
        endcase
      end
      else if (scl_fall)
      begin
        unique case (state)
          smbus_cfg_pkg::st_addr:
          begin
            if (bit_cnt == 4'h8)
            begin
              // A read is only answered once a command has set the offset.
              if (rx_shift[7:1] == smbus_cfg_pkg::DEV_ADDR && (!rx_shift[0] || cmd_valid))
              begin
                bus.dev_sda_oe <= 1'b1;
                state <= smbus_cfg_pkg::st_ack;
                after_ack <= rx_shift[0] ? smbus_cfg_pkg::st_rdata : smbus_cfg_pkg::st_cmd;
              end
              else
              begin
                state <= smbus_cfg_pkg::st_ignore;
              end
            end
          end
          smbus_cfg_pkg::st_cmd:
          begin
            if (bit_cnt == 4'h8)
            begin
              if (rx_shift[smbus_cfg_pkg::CMD_BYTE_OP_BIT])
              begin
                offset <= rx_shift[6:0];
                cmd_valid <= 1'b1;
                bus.dev_sda_oe <= 1'b1;
                state <= smbus_cfg_pkg::st_ack;
                after_ack <= smbus_cfg_pkg::st_wdata;
              end
              else
              begin
                // Block and word forms are not served; leaving the line high refuses them.
                state <= smbus_cfg_pkg::st_ignore;
              end
            end
          end
          smbus_cfg_pkg::st_wdata:
          begin
            if (bit_cnt == 4'h8)
            begin
              wr_en <= 1'b1;
              wr_data <= rx_shift;
              bus.dev_sda_oe <= 1'b1;
              state <= smbus_cfg_pkg::st_ack;
              after_ack <= smbus_cfg_pkg::st_ignore;
            end
          end
          smbus_cfg_pkg::st_ack:
          begin
            state <= after_ack;
            bit_cnt <= 4'h0;
            if (after_ack == smbus_cfg_pkg::st_rdata)
            begin
              bus.dev_sda_oe <= !rd_byte[7];
              tx_shift <= {rd_byte[6:0], 1'b0};
            end
            else
            begin
              bus.dev_sda_oe <= 1'b0;
            end
          end
          smbus_cfg_pkg::st_rdata:
          begin
            if (bit_cnt == 4'h8)
            begin
              bus.dev_sda_oe <= 1'b0;
              state <= smbus_cfg_pkg::st_rack;
            end
            else
            begin
              bus.dev_sda_oe <= !tx_shift[7];
              tx_shift <= {tx_shift[6:0], 1'b0};
            end
          end
          smbus_cfg_pkg::st_idle, smbus_cfg_pkg::st_rack, smbus_cfg_pkg::st_ignore: ;
        endcase
      end
    end
  end

  // The line is only ever pulled low; a one is sent by letting go.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      bus.dev_sda_out <= 1'b0;
    end
    else
    begin
      bus.dev_sda_out <= 1'b0;
    end
  end

  // Configuration bytes; reserved bits are masked on the way in so they stay zero.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      spread_and_freq_select <= smbus_cfg_pkg::RST_SPREAD_FREQ;
      cpu_agp_usb_clock_enables <= smbus_cfg_pkg::RST_CPU_AGP_USB;
      pci_clock_enables_low <= smbus_cfg_pkg::RST_PCI_LOW;
      pci_ref_clock_enables_high <= smbus_cfg_pkg::RST_PCI_REF;
    end
    else if (wr_en)
    begin
      unique case (offset)
        smbus_cfg_pkg::OFF_SPREAD_FREQ: spread_and_freq_select <= wr_data & smbus_cfg_pkg::MASK_SPREAD_FREQ;
        smbus_cfg_pkg::OFF_CPU_AGP_USB: cpu_agp_usb_clock_enables <= wr_data & smbus_cfg_pkg::MASK_CPU_AGP_USB;
        smbus_cfg_pkg::OFF_PCI_LOW: pci_clock_enables_low <= wr_data & smbus_cfg_pkg::MASK_PCI_LOW;
        smbus_cfg_pkg::OFF_PCI_REF: pci_ref_clock_enables_high <= wr_data & smbus_cfg_pkg::MASK_PCI_REF;
        default: ;
      endcase
    end
  end

  // Straps are caught once, on the third edge after reset; earlier the synchroniser still holds its reset value.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      strap_sync0 <= 5'h00;
      strap_sync1 <= 5'h00;
      strap_latched <= 5'h00;
      strap_wait <= 2'h0;
    end
    else
    begin
      strap_sync0 <= fs_strap;
      strap_sync1 <= strap_sync0;
      if (strap_wait != 2'h3)
        strap_wait <= 2'(strap_wait + 2'h1);
      if (strap_wait == 2'h2)
        strap_latched <= strap_sync1;
    end
  end

  // Operating frequency: the software bits win only while override is set.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      freq_select <= 5'h00;
    end
    else
    begin
      freq_select <= strap_override ? {sw_freq_bit4, spread_and_freq_select[3:0]} : strap_latched;
    end
  end

endmodule

/* File: src/smbus_cfg_host.sv */
`timescale 1ns/100ps
// Host end: software writes a command through APB, the host runs one byte transaction on the link.
module smbus_cfg_host (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  smbus_if.host bus
);

  logic [1:0] sda_sync;
  logic is_read;
  logic [7:0] cmd_code;
  logic [7:0] tx_data;
  logic [7:0] rx_data;
  logic running;
  logic nack;
  logic abort;
  logic [5:0] pos;
  logic [1:0] phase;
  logic [3:0] qcnt;
  logic launch;
  smbus_cfg_pkg::slot_kind_t kind;
  logic slot_bit;

  // What happens in a given bit time, for the byte write or the byte read.
  function automatic smbus_cfg_pkg::slot_kind_t slot_kind(input logic [5:0] p, input logic rd);
    if (p == smbus_cfg_pkg::POS_START || (rd && p == smbus_cfg_pkg::POS_RSTART))
      return smbus_cfg_pkg::k_start;
    if (p == smbus_cfg_pkg::POS_ADDR_ACK || p == smbus_cfg_pkg::POS_CMD_ACK)
      return smbus_cfg_pkg::k_ack;
    if (!rd && p == smbus_cfg_pkg::POS_WR_ACK)
      return smbus_cfg_pkg::k_ack;
    if (!rd && p == smbus_cfg_pkg::POS_WR_STOP)
      return smbus_cfg_pkg::k_stop;
    if (rd && p == smbus_cfg_pkg::POS_RD_ACK)
      return smbus_cfg_pkg::k_ack;
    if (rd && p >= smbus_cfg_pkg::POS_RD_FIRST && p <= smbus_cfg_pkg::POS_RD_LAST)
      return smbus_cfg_pkg::k_rx;
    if (rd && p == smbus_cfg_pkg::POS_RD_STOP)
      return smbus_cfg_pkg::k_stop;
    return smbus_cfg_pkg::k_bit;
  endfunction

  // Level sent in a plain bit time, most significant bit first.
  function automatic logic slot_value(input logic [5:0] p, input logic rd, input logic [7:0] cmd,
                                      input logic [7:0] dat);
    if (p < smbus_cfg_pkg::POS_DIR)
      return smbus_cfg_pkg::DEV_ADDR[3'(6'h08 - p)];
    if (p > smbus_cfg_pkg::POS_ADDR_ACK && p < smbus_cfg_pkg::POS_CMD_ACK)
      return cmd[3'(6'h12 - p)];
    if (!rd && p > smbus_cfg_pkg::POS_RSTART - 6'h01 && p < smbus_cfg_pkg::POS_WR_ACK)
      return dat[3'(6'h1b - p)];
    if (rd && p > smbus_cfg_pkg::POS_RSTART && p < smbus_cfg_pkg::POS_RD_DIR)
      return smbus_cfg_pkg::DEV_ADDR[3'(6'h1b - p)];
    // Read direction bit and the closing not-acknowledge both send a one.
    return rd && (p == smbus_cfg_pkg::POS_RD_DIR || p == smbus_cfg_pkg::POS_RD_NACK);
  endfunction

  assign kind = slot_kind(pos, is_read);
  assign slot_bit = slot_value(pos, is_read, cmd_code, tx_data);
  assign launch = psel && penable && pready && pwrite && paddr == smbus_cfg_pkg::APB_CTRL && !running;

  // APB slave with one wait state, so read data and error come from flops.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && paddr != smbus_cfg_pkg::APB_CTRL &&
                 paddr != smbus_cfg_pkg::APB_STATUS;
      if (psel && penable && !pready && !pwrite && paddr == smbus_cfg_pkg::APB_CTRL)
        prdata <= {15'h0000, is_read, cmd_code, tx_data};
      else if (psel && penable && !pready && !pwrite && paddr == smbus_cfg_pkg::APB_STATUS)
        prdata <= {16'h0000, rx_data, 6'h00, nack, running};
      else
        prdata <= 32'h0000_0000;
    end
  end

  // Command capture; a write while a transaction runs is dropped.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      is_read <= 1'b0;
      cmd_code <= 8'h00;
      tx_data <= 8'h00;
    end
    else if (launch)
    begin
      is_read <= pwdata[smbus_cfg_pkg::CTRL_READ_BIT];
      cmd_code <= pwdata[15:8];
      tx_data <= pwdata[7:0];
    end
  end

  // Only the data line is read back; the clock is ours and clock stretching is not honoured.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      sda_sync <= 2'h3;
    else
      sda_sync <= {sda_sync[0], bus.sda};
  end

  // Each bit time is four quarters: clock low and set data, clock high, sample or
  // make start/stop while high, clock low. Data never moves while the clock is high
  // except to make a start or a stop.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      running <= 1'b0;
      nack <= 1'b0;
      abort <= 1'b0;
      pos <= 6'h00;
      phase <= 2'h0;
      qcnt <= 4'h0;
      rx_data <= 8'h00;
      bus.scl_oe <= 1'b0;
      bus.host_sda_oe <= 1'b0;
      bus.scl_out <= 1'b0;
      bus.host_sda_out <= 1'b0;
    end
    else if (launch)
    begin
      running <= 1'b1;
      nack <= 1'b0;
      abort <= 1'b0;
      pos <= smbus_cfg_pkg::POS_START;
      phase <= 2'h0;
      qcnt <= 4'h0;
    end
    else if (running)
    begin
      if (qcnt == 4'h0)
      begin
        unique case (phase)
          2'h0:
          begin
            bus.scl_oe <= 1'b1;
            bus.host_sda_oe <= (kind == smbus_cfg_pkg::k_bit && !slot_bit) || kind == smbus_cfg_pkg::k_stop;
          end
          2'h1: bus.scl_oe <= 1'b0;
          2'h2:
          begin
            if (kind == smbus_cfg_pkg::k_start)
              bus.host_sda_oe <= 1'b1;
            else if (kind == smbus_cfg_pkg::k_stop)
              bus.host_sda_oe <= 1'b0;
            else if (kind == smbus_cfg_pkg::k_ack && sda_sync[1])
            begin
              // No answer from the device: skip ahead to the stop.
              nack <= 1'b1;
              abort <= 1'b1;
            end
            else if (kind == smbus_cfg_pkg::k_rx)
              rx_data <= {rx_data[6:0], sda_sync[1]};
          end
          2'h3:
          begin
            if (kind == smbus_cfg_pkg::k_stop)
              running <= 1'b0;
            else
              bus.scl_oe <= 1'b1;
          end
        endcase
      end
      if (qcnt == smbus_cfg_pkg::SCL_QTR_CYCLES - 4'h1)
      begin
        qcnt <= 4'h0;
        phase <= 2'(phase + 2'h1);
        if (phase == 2'h3)
        begin
          abort <= 1'b0;
          if (abort)
            pos <= is_read ? smbus_cfg_pkg::POS_RD_STOP : smbus_cfg_pkg::POS_WR_STOP;
          else
            pos <= 6'(pos + 6'h01);
        end
      end
      else
      begin
        qcnt <= 4'(qcnt + 4'h1);
      end
    end
  end

endmodule

/* File: sim/smbus_cfg_sva.sv */
`timescale 1ns/100ps
// Watches the shared link and follows the bit position of each frame.
module smbus_cfg_sva (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic host_sda_out,
  input wire logic host_sda_oe,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic in_frame;
  logic [5:0] pos;
  logic [7:0] addr;
  logic [7:0] cmd;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // Start and stop are sda edges while scl stays high.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      in_frame <= 1'b0;
    else if (scl && $fell(sda))
      in_frame <= 1'b1;
    else if (scl && $rose(sda))
      in_frame <= 1'b0;
  end

  // A repeated start restarts the count, so read frames reuse the same positions.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      pos <= 6'h00;
    else if (scl && $fell(sda))
      pos <= 6'h01;
    else if ($rose(scl))
      pos <= pos + 6'h01;
  end

  // Address and command shift in most significant bit first.
  always_ff @(posedge mclk)
  begin
    if ($rose(scl) && pos > 6'h00 && pos < 6'h08)
      addr <= {addr[6:0], sda};
    if ($rose(scl) && pos > 6'h09 && pos < 6'h12)
      cmd <= {cmd[6:0], sda};
  end

  a_scl_high_len: assert property ($rose(scl) |-> scl[*8])
    else $error("scl high phase too short");
  a_scl_low_len: assert property ($fell(scl) |-> !scl[*4] ##[1:5] scl)
    else $error("scl low phase out of range");
  a_dev_stable: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device moved sda while scl high");
  a_idle_quiet: assert property (!in_frame |-> !dev_sda_oe)
    else $error("device drives sda outside a frame");
  a_addr_ack: assert property ($rose(scl) && pos == 6'h09 && !sda |-> addr[6:0] == smbus_cfg_pkg::DEV_ADDR)
    else $error("foreign address acknowledged");
  a_cmd_ack: assert property ($rose(scl) && pos == 6'h12 && !sda |-> cmd[7])
    else $error("command without top bit acknowledged");
  a_host_ack_free: assert property ($rose(scl) && (pos == 6'h09 || pos == 6'h12 || pos == 6'h1b)
    |-> !host_sda_oe)
    else $error("host holds sda in an acknowledge slot");
  a_data_ack: assert property ($rose(scl) && pos == 6'h1b |-> !sda)
    else $error("write data not acknowledged");
  a_release_idle: assert property ($rose(rstn) |-> !scl_oe && !host_sda_oe && !dev_sda_oe)
    else $error("link not released after reset");
  a_od_values: assert property (!scl_out && !host_sda_out && !dev_sda_out)
    else $error("open drain value not low");

  c_write_ack: cover property ($rose(scl) && pos == 6'h1b && !sda);
  c_cmd_refused: cover property ($rose(scl) && pos == 6'h12 && sda);
  c_rstart: cover property (in_frame && scl && $fell(sda));
endmodule

/* File: sim/clock_gen_smbus_config_regs_test.sv */
`timescale 1ns/100ps
// Host and device joined on one link; software traffic comes over APB.
module clock_gen_smbus_config_regs_test;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [4:0] fs_strap = 5'h00;
  logic strap_override = 1'b0;
  logic sw_freq_bit4 = 1'b0;
  wire [7:0] cfg_port [4];
  logic [4:0] freq_select;
  logic [7:0] mdl [4];
  logic [7:0] msk [4];
  logic [33:0] exp_q [$];
  logic [31:0] last_rd;
  logic [7:0] last_byte = 8'h00;
  int n_errors = 0;
  int check_count = 0;
  int seed = 32'h0000_9d82;

  smbus_if lnk();
  smbus_cfg_host i_smbus_cfg_host (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(lnk.host));
  smbus_cfg_device i_smbus_cfg_device (.mclk(mclk), .rstn(rstn), .bus(lnk.device), .fs_strap(fs_strap),
    .strap_override(strap_override), .sw_freq_bit4(sw_freq_bit4), .spread_and_freq_select(cfg_port[0]),
    .cpu_agp_usb_clock_enables(cfg_port[1]), .pci_clock_enables_low(cfg_port[2]),
    .pci_ref_clock_enables_high(cfg_port[3]), .freq_select(freq_select));
  smbus_cfg_sva i_smbus_cfg_sva (.mclk(mclk), .rstn(rstn), .scl_out(lnk.scl_out), .scl_oe(lnk.scl_oe),
    .host_sda_out(lnk.host_sda_out), .host_sda_oe(lnk.host_sda_oe), .dev_sda_out(lnk.dev_sda_out),
    .dev_sda_oe(lnk.dev_sda_oe), .scl(lnk.scl), .sda(lnk.sda));

  // Half period of 50 ns gives the 10 MHz clock.
  always #50 mclk = ~mclk;

  task stop_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk_bus(input logic [32:0] e, input logic [32:0] g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task chk_port(input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // Each completed read takes the oldest note; the top bit says whether to compare.
  always @(posedge mclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      if (exp_q[0][33])
        chk_bus(exp_q[0][32:0], {pslverr, prdata});
      exp_q.delete(0);
    end
  end

  // Request is held until pready is seen; one idle cycle keeps drivers apart.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
    if (!wr)
      exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // No count of wait states is assumed; only the watchdog ends a transfer that never completes.
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    last_rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wait_idle();
    do
    begin
      apb(1'b0, smbus_cfg_pkg::APB_STATUS, 32'h0000_0000, 34'h0);
    end
    while (last_rd[0] !== 1'b0);
  endtask

  task automatic xfer(input logic rd, input logic [7:0] cmd, input logic [7:0] d);
    apb(1'b1, smbus_cfg_pkg::APB_CTRL, {15'h0000, rd, cmd, d}, 34'h0);
    wait_idle();
  endtask

  task automatic status(input logic nack);
    apb(1'b0, smbus_cfg_pkg::APB_STATUS, 32'h0000_0000, {2'b10, 16'h0000, last_byte, 6'h00, nack, 1'b0});
  endtask

  task automatic rd_cmp(input logic [1:0] o);
    xfer(1'b1, {6'h20, o}, 8'h00);
    last_byte = mdl[o];
    status(1'b0);
  endtask

  // Main sequence; the straps are random but held through the run.
  initial
  begin
    logic [7:0] d;
    fs_strap <= 5'($random(seed));
    mdl = '{smbus_cfg_pkg::RST_SPREAD_FREQ, smbus_cfg_pkg::RST_CPU_AGP_USB, smbus_cfg_pkg::RST_PCI_LOW,
      smbus_cfg_pkg::RST_PCI_REF};
    msk = '{smbus_cfg_pkg::MASK_SPREAD_FREQ, smbus_cfg_pkg::MASK_CPU_AGP_USB, smbus_cfg_pkg::MASK_PCI_LOW,
      smbus_cfg_pkg::MASK_PCI_REF};
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 4; i++)
      rd_cmp(i[1:0]);
    // Random writes visit every byte and all four spread codes; reserved bits must read zero.
    for (int i = 0; i < 16; i++)
    begin
      d = 8'($random(seed));
      if (i[1:0] == 2'b00)
        d[6:4] = {1'b0, i[3:2]};
      xfer(1'b0, {6'h20, i[1:0]}, d);
      mdl[i[1:0]] = d & msk[i[1:0]];
      chk_port(mdl[i[1:0]], cfg_port[i[1:0]]);
      rd_cmp(i[1:0]);
    end
    // Offsets past the map are acknowledged but hold nothing.
    xfer(1'b0, 8'h85, 8'hff);
    status(1'b0);
    xfer(1'b1, 8'h85, 8'h00);
    last_byte = 8'h00;
    status(1'b0);
    // A command without the top bit is refused and changes nothing.
    xfer(1'b0, 8'h01, 8'h00);
    status(1'b1);
    chk_port(mdl[1], cfg_port[1]);
    // An initialisation write keeps every reserved bit at zero.
    xfer(1'b0, 8'h83, smbus_cfg_pkg::RST_PCI_REF);
    chk_port(smbus_cfg_pkg::RST_PCI_REF, cfg_port[3]);
    // Software frequency bits reach the output only with the override set.
    for (int i = 0; i < 4; i++)
    begin
      strap_override <= i[0];
      sw_freq_bit4 <= i[1];
      repeat (3) @(posedge mclk);
      chk_port(i[0] ? {3'b000, i[1], mdl[0][3:0]} : {3'b000, fs_strap}, {3'b000, freq_select});
    end
    // A launch while busy is dropped; the first command still lands.
    apb(1'b1, smbus_cfg_pkg::APB_CTRL, 32'h0000_825a, 34'h0);
    apb(1'b1, smbus_cfg_pkg::APB_CTRL, 32'h0000_83a5, 34'h0);
    apb(1'b0, smbus_cfg_pkg::APB_CTRL, 32'h0000_0000, {2'b10, 32'h0000_825a});
    wait_idle();
    chk_port(8'h5a, cfg_port[2]);
    apb(1'b0, 8'h08, 32'h0000_0000, {2'b11, 32'h0000_0000});
    stop_test();
  end

  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    stop_test();
  end
endmodule
